// >>> core/alarm_match_registers.sv
// Alarm setting registers and match logic of the real-time clock.
// Assumes a serial engine issues reg_req and samples rd_data next cycle.
`timescale 1ns/10ps
module alarm_match_registers
	import alarm_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register access from the serial engine
	input wire reg_req_type reg_req,
	output logic [7:0] rd_data,
	// Time counters and status
	input wire time_type now,
	input wire logic day_carry,
	input wire logic osc_stop_flag,
	// Alarm results
	output logic week_alarm_match,
	output logic daily_alarm_match,
	output logic week_alarm_event,
	output logic daily_alarm_event
);

	logic [6:0] week_min;
	logic [5:0] week_hour;
	logic [6:0] week_days;
	logic [6:0] daily_min;
	logic [5:0] daily_hour;
	logic [2:0] weekday;
	logic weekday_load;
	logic next_week_match;
	logic next_daily_match;
	logic [7:0] next_rd_data;

	// Write of a register at an address
	function automatic logic write_hit(input reg_req_type r,
		input logic [3:0] a);
		write_hit = r.wr && (r.addr == a);
	endfunction

	// BCD minute and hour equality, bit 5 compared as stored
	function automatic logic time_equal(input time_type t,
		input logic [6:0] m, input logic [5:0] h);
		time_equal = (t.minute == m) && (t.hour == h);
	endfunction

	// Weekday load follows the other writes: ignored during oscillation stop
	assign weekday_load = write_hit(reg_req, ADDR_WEEKDAY) && !osc_stop_flag;

	weekday_counter u_weekday (
		.clock(clock),
		.rstn(rstn),
		.day_carry(day_carry),
		.load(weekday_load),
		.load_value(reg_req.wdata[2:0]),
		.count(weekday)
	);

	// Week-alarm storage; oscillation stop forces a plain value
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			week_min <= ALARM_RESET[6:0];
			week_hour <= ALARM_RESET[5:0];
			week_days <= ALARM_RESET[6:0];
		end else if (osc_stop_flag) begin
			week_min <= ALARM_RESET[6:0];
			week_hour <= ALARM_RESET[5:0];
			week_days <= ALARM_RESET[6:0];
		end else begin
			if (write_hit(reg_req, ADDR_WEEK_MIN)) begin
				week_min <= reg_req.wdata[6:0];
			end
			if (write_hit(reg_req, ADDR_WEEK_HOUR)) begin
				week_hour <= reg_req.wdata[5:0];
			end
			if (write_hit(reg_req, ADDR_WEEK_DAYS)) begin
				week_days <= reg_req.wdata[6:0];
			end
		end
	end

	// Daily-alarm storage
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			daily_min <= ALARM_RESET[6:0];
			daily_hour <= ALARM_RESET[5:0];
		end else if (osc_stop_flag) begin
			daily_min <= ALARM_RESET[6:0];
			daily_hour <= ALARM_RESET[5:0];
		end else begin
			if (write_hit(reg_req, ADDR_DAILY_MIN)) begin
				daily_min <= reg_req.wdata[6:0];
			end
			if (write_hit(reg_req, ADDR_DAILY_HOUR)) begin
				daily_hour <= reg_req.wdata[5:0];
			end
		end
	end

	// Read mux; unused bits forced to zero by the masks
	always_comb begin
		if (reg_req.addr == ADDR_WEEK_MIN) begin
			next_rd_data = {1'b0, week_min} & MINUTE_MASK;
		end else if (reg_req.addr == ADDR_WEEK_HOUR) begin
			next_rd_data = {2'b00, week_hour} & HOUR_MASK;
		end else if (reg_req.addr == ADDR_WEEK_DAYS) begin
			next_rd_data = {1'b0, week_days} & DAY_MASK;
		end else if (reg_req.addr == ADDR_DAILY_MIN) begin
			next_rd_data = {1'b0, daily_min} & MINUTE_MASK;
		end else if (reg_req.addr == ADDR_DAILY_HOUR) begin
			next_rd_data = {2'b00, daily_hour} & HOUR_MASK;
		end else if (reg_req.addr == ADDR_WEEKDAY) begin
			next_rd_data = {5'h00, weekday} & WEEKDAY_MASK;
		end else begin
			next_rd_data = READ_NONE;
		end
	end

	// Registered read data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data <= READ_NONE;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// Match conditions; empty mask means no mask bit can be set
	// A written count of 7 has no mask bit, so it never qualifies
	assign next_week_match = time_equal(now, week_min, week_hour)
		&& (week_days != 7'h00)
		&& (weekday <= WEEKDAY_LAST)
		&& week_days[weekday[2:0] <= WEEKDAY_LAST ? weekday : 3'h0];
	assign next_daily_match = time_equal(now, daily_min, daily_hour);

	// Match levels and one-cycle events on their rise
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			week_alarm_match <= 1'b0;
			daily_alarm_match <= 1'b0;
			week_alarm_event <= 1'b0;
			daily_alarm_event <= 1'b0;
		end else begin
			week_alarm_match <= next_week_match;
			daily_alarm_match <= next_daily_match;
			week_alarm_event <= next_week_match && !week_alarm_match;
			daily_alarm_event <= next_daily_match && !daily_alarm_match;
		end
	end

endmodule

// >>> core/weekday_counter.sv
// Day-of-week counter, three bits counting 0 to 6 and wrapping.
// Assumes day_carry is a one-cycle pulse from the day-of-month counter.
`timescale 1ns/10ps
module weekday_counter
	import alarm_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Control
	input wire logic day_carry,
	input wire logic load,
	input wire logic [2:0] load_value,
	// State
	output logic [2:0] count
);

	// Load wins over carry; step 0..6 then back to 0
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= WEEKDAY_RESET;
		end else if (load) begin
			count <= load_value;
		end else if (day_carry) begin
			if (count >= WEEKDAY_LAST) begin
				count <= WEEKDAY_RESET;
			end else begin
				count <= count + 3'h1;
			end
		end
	end

endmodule

// >>> dv/alarm_match_checker.sv
// Checker on the alarm block ports.
// Assumes it is bound into every alarm block instance.
`timescale 1ns/10ps
module alarm_match_checker
	import alarm_pkg::*;
(
	// Watched ports
	input wire logic clock,
	input wire logic rstn,
	input wire reg_req_type reg_req,
	input wire logic [7:0] rd_data,
	input wire logic osc_stop_flag,
	input wire logic week_alarm_match,
	input wire logic daily_alarm_match,
	input wire logic week_alarm_event,
	input wire logic daily_alarm_event
);
	logic [3:0] pa;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Address behind the current read data
	always_ff @(posedge clock) pa <= reg_req.addr;
	property p_wmin; pa == ADDR_WEEK_MIN |-> !rd_data[7]; endproperty
	a_wmin: assert property (p_wmin) else $error("wmin");
	property p_whour; pa == ADDR_WEEK_HOUR |-> !rd_data[7:6]; endproperty
	a_whour: assert property (p_whour) else $error("whour");
	property p_days; pa == ADDR_WEEK_DAYS |-> !rd_data[7]; endproperty
	a_days: assert property (p_days) else $error("days");
	property p_dmin; pa == ADDR_DAILY_MIN |-> !rd_data[7]; endproperty
	a_dmin: assert property (p_dmin) else $error("dmin");
	property p_dhour; pa == ADDR_DAILY_HOUR |-> !rd_data[7:6]; endproperty
	a_dhour: assert property (p_dhour) else $error("dhour");
	property p_wevt; week_alarm_event == $rose(week_alarm_match); endproperty
	a_wevt: assert property (p_wevt) else $error("wevt");
	property p_devt; daily_alarm_event |->
		$rose(daily_alarm_match) ##1 !daily_alarm_event; endproperty
	a_devt: assert property (p_devt) else $error("devt");
	property p_osc; osc_stop_flag[*3] ##0 pa inside {[4'h8:4'hc]} |->
		!rd_data; endproperty
	a_osc: assert property (p_osc) else $error("osc");
endmodule
bind alarm_match_registers alarm_match_checker u_chk (.clock, .rstn,
	.reg_req, .rd_data, .osc_stop_flag, .week_alarm_match,
	.daily_alarm_match, .week_alarm_event, .daily_alarm_event);

// >>> dv/host_model.sv
// Host model issuing single register accesses.
// Assumes one calling process at a time.
`timescale 1ns/10ps
module host_model
	import alarm_pkg::*;
(
	// Answer
	input wire logic clock,
	input wire logic [7:0] rd_data,
	// Request
	output reg_req_type reg_req
);
	// Idle at time zero
	initial reg_req = '0;
	// One-cycle write; callers load occurring times only
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock) reg_req = '{1'h1, a, d};
		@(negedge clock) reg_req = '{1'h0, a, ~d};
	endtask
	// Address held over two edges, then data taken
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clock) reg_req = '{1'h0, a, 8'h00};
		repeat (2) @(negedge clock);
		d = rd_data;
	endtask
endmodule

// >>> dv/tb_alarm_match_registers.sv
// Self-checking bench for the alarm match registers.
// Assumes host model and bound checker compiled alongside.
`timescale 1ns/10ps
module tb_alarm_match_registers
	import alarm_pkg::*;
;
	logic clock, rstn, day_carry, osc_stop_flag, wm, dm, we, de;
	logic [7:0] rd_data, d;
	time_type now;
	reg_req_type reg_req;
	int n_mismatch, comparisons, cyc;
	wire logic [7:0] fl = {4'h0, wm, dm, we, de};
	alarm_match_registers u_dut (.clock, .rstn, .reg_req, .rd_data, .now,
		.day_carry, .osc_stop_flag, .week_alarm_match(wm),
		.daily_alarm_match(dm), .week_alarm_event(we), .daily_alarm_event(de));
	host_model u_host (.clock, .rd_data, .reg_req);
	// Clock
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	task chk(input logic [7:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %0t got %h want %h", $time, s, e);
		end
	endtask
	task rchk(input logic [3:0] a, input logic [7:0] e);
		u_host.rd(a, d);
		chk(d, e);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task t_regs;
		u_host.wr(ADDR_WEEK_MIN, 8'hd9);
		u_host.wr(ADDR_WEEK_HOUR, 8'he3);
		u_host.wr(ADDR_WEEK_DAYS, 8'hff);
		u_host.wr(ADDR_DAILY_MIN, 8'hb0);
		u_host.wr(ADDR_DAILY_HOUR, 8'hd2);
		u_host.wr(4'h5, 8'h3c);
		rchk(ADDR_WEEK_MIN, 8'h59);
		rchk(ADDR_WEEK_HOUR, 8'h23);
		rchk(ADDR_WEEK_DAYS, 8'h7f);
		rchk(ADDR_DAILY_MIN, 8'h30);
		rchk(ADDR_DAILY_HOUR, 8'h12);
		rchk(4'h5, 8'h00);
	endtask
	// Midnight code on the daily alarm
	task t_daily;
		@(negedge clock) now = '{7'h30, 6'h12};
		@(negedge clock) chk(fl, 8'h05);
		@(negedge clock) chk(fl, 8'h04);
		now = '{7'h31, 6'h12};
		@(negedge clock) chk(fl, 8'h00);
	endtask
	// Noon code, day mask, empty mask, weekday wrap
	task t_week;
		u_host.wr(ADDR_WEEK_MIN, 8'h00);
		u_host.wr(ADDR_WEEK_HOUR, 8'h32);
		u_host.wr(ADDR_WEEK_DAYS, 8'h02);
		now = '{7'h00, 6'h32};
		@(negedge clock) chk(fl, 8'h00);
		day_carry = 1'h1;
		@(negedge clock) day_carry = 1'h0;
		@(negedge clock) chk(fl, 8'h0a);
		u_host.wr(ADDR_WEEK_DAYS, 8'h00);
		@(negedge clock) chk(fl, 8'h00);
		repeat (6) begin
			@(negedge clock) day_carry = 1'h1;
			@(negedge clock) day_carry = 1'h0;
		end
		rchk(ADDR_WEEKDAY, 8'h00);
	endtask
	task t_osc;
		@(negedge clock) osc_stop_flag = 1'h1;
		u_host.wr(ADDR_DAILY_MIN, 8'h45);
		rchk(ADDR_DAILY_MIN, 8'h00);
		osc_stop_flag = 1'h0;
	endtask
	// Main sequence
	initial begin
		rstn = 1'h0;
		day_carry = 1'h0;
		osc_stop_flag = 1'h0;
		now = '0;
		repeat (3) @(negedge clock);
		rstn = 1'h1;
		t_regs();
		t_daily();
		t_week();
		t_osc();
		tally_and_finish();
	end
endmodule

// >>> shared/alarm_pkg.sv
// Package for the alarm match registers: offsets, masks, reset values
// and the structs that carry time and register requests.
// Assumes the serial engine and time counters sit outside this block.
package alarm_pkg;

	// Register offsets on the internal 4-bit register address
	localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
	localparam logic [3:0] ADDR_WEEK_MIN = 4'h8;
	localparam logic [3:0] ADDR_WEEK_HOUR = 4'h9;
	localparam logic [3:0] ADDR_WEEK_DAYS = 4'ha;
	localparam logic [3:0] ADDR_DAILY_MIN = 4'hb;
	localparam logic [3:0] ADDR_DAILY_HOUR = 4'hc;

	// Implemented bits of each register; the rest read as zero
	localparam logic [7:0] MINUTE_MASK = 8'h7f;
	localparam logic [7:0] HOUR_MASK = 8'h3f;
	localparam logic [7:0] DAY_MASK = 8'h7f;
	localparam logic [7:0] WEEKDAY_MASK = 8'h07;

	// Field positions
	localparam int HOUR_PM_BIT = 5;
	localparam int MIN_TENS_BIT = 6;

	// Values after reset or oscillation stop, and the last weekday count before the wrap
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [2:0] WEEKDAY_RESET = 3'h0;
	localparam logic [2:0] WEEKDAY_LAST = 3'h6;
	localparam logic [7:0] READ_NONE = 8'h00;

	// Current time from the time counters, BCD
	typedef struct packed {
		logic [6:0] minute;
		logic [5:0] hour;
	} time_type;

	// One register access from the serial engine
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

endpackage
